// ### rtl/bsd_core.sv
// sine drive core: speed select, duty ramp, faults, lock retry,
// eeprom load and the i2c register map
// assumes eeprom data arrives one cycle after ee_addr, adc codes
// are on this clock; speed, direction and i2c pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - regulator target 5 V when select is 0, 3.3 V when 1
// - shut down above trip temperature, resume below trip minus hysteresis
// - status bit 7 at 0x10 stays set during thermal shutdown
// - overcurrent puts all phase drivers high impedance until it clears
// - overcurrent sets status bit 5 at 0x10
// - rotor lock stops driving the phases at once
// - after release delay drive restarts; persisting lock repeats the cycle
// - lock holds status bit 4 at 0x10 and records its cause
// - speed command from pin pwm duty, pin analog level or register
// - peak duty follows command, held back by limiting functions
// - third harmonic sine, one phase grounded, two phases modulated
// - peak duty is the highest duty within one electrical cycle
// - peak amplitude scales linearly with peak duty
// - eeprom copied to operating registers after power-on and wake
// - host register writes replace eeprom values except while an eeprom load is in progress
// - tach output toggles every half electrical turn, once per 32 commutation steps
// - direction input level sets commutation direction
// - phase current always, supply periodically sampled and readable
module bsd_core import bsd_pkg::*; #(
  parameter int LOCK_CYCLES = LOCK_OFF_CYCLES  // lock release time
) (
  input  wire logic       clock,           // 200 MHz
  input  wire logic       reset,           // async, high
  input  wire logic       scl_pin,         // i2c clock pin
  input  wire logic       sda_pin,         // i2c data pin level
  output logic            sda_out,         // i2c data drive value
  output logic            sda_oe,          // i2c data pulled low
  input  wire logic       speed_pin,       // speed pin, pwm mode
  input  wire logic [8:0] speed_adc,       // speed pin, analog code
  input  wire logic       direction_input, // rotation direction pin
  input  wire logic [7:0] temp_code,       // die temperature code
  input  wire logic [7:0] phase_current,   // fet current code
  input  wire logic [7:0] supply_adc,      // supply voltage code
  input  wire logic       lock_detect,     // rotor lock seen
  input  wire logic [2:0] lock_cause,      // which lock check fired
  input  wire logic       duty_hold,       // current limit, no rise
  input  wire logic       avs_hold,        // anti_voltage_surge, no fall
  input  wire logic       sleep_exit,      // wake pulse
  input  wire logic [7:0] ee_data,         // eeprom word
  output logic [3:0]      ee_addr,         // eeprom word index
  output var  bsd_phase_t phase_drive,     // phase pwm and enables
  output logic            tach_output,     // speed indication
  output logic            vreg_target_3v3  // 1: 3.3 V, 0: 5 V
);

  typedef struct packed {
    logic                      spd_s1, spd_s2, dir_s1, dir_s2;
    logic [8:0]                win, high, pwm_cmd, speed_i2c, duty;
    logic [CFG_WORDS-1:0][7:0] cfg;
    logic                      ld_busy, ld_pend;
    logic [3:0]                ee_addr, ld_slot;
    logic                      hot, oc, oc_flag, lock_wait;
    logic [29:0]               lock_timer;
    logic [2:0]                cause;
    logic [7:0]                ramp, cur, sup;
    logic [15:0]               acc;
    logic [10:0]               sup_cnt;
    logic                      step, tach;
  } bsd_core_t;

  bsd_core_t  s, n;
  bsd_bus_t   bus;
  logic [7:0] rdata, status;
  logic [8:0] cmd, target, cap;
  logic [7:0] cfg_idx;
  logic       turn, drive_en, stat_rd;

  // ==========================================================
  // i2c target and sine modulator
  bsd_i2c_tgt u_i2c (
    .clock   (clock),
    .reset   (reset),
    .scl_pin (scl_pin),
    .sda_pin (sda_pin),
    .rdata   (rdata),
    .sda_oe  (sda_oe),
    .bus     (bus)
  );

  bsd_sine_mod u_sine (
    .clock   (clock),
    .reset   (reset),
    .step    (s.step),
    .reverse (s.dir_s2),
    .peak    (s.duty),
    .enable  (drive_en),
    .drive   (phase_drive),
    .turn    (turn)
  );

  // ==========================================================
  // register read map
  assign cfg_idx = 8'(bus.addr - REG_CFG_BASE);
  always_comb begin
    status = 8'h00;
    status[BIT_OVER_TEMP] = s.hot;
    status[BIT_OVER_CURR] = s.oc_flag;
    status[BIT_LOCK] = s.lock_wait;
    case (bus.addr)
      REG_SPEED_LO:     rdata = s.speed_i2c[7:0];
      REG_SPEED_HI:     rdata = {7'h00, s.speed_i2c[8]};
      REG_FAULT_STATUS: rdata = status;
      REG_FAULT_CAUSE:  rdata = {5'h00, s.cause};
      REG_CURRENT:      rdata = s.cur;
      REG_SUPPLY:       rdata = s.sup;
      REG_DUTY:         rdata = s.duty[8:1];
      default:
        rdata = (cfg_idx < 8'(CFG_WORDS)) ? s.cfg[cfg_idx[3:0]] : 8'h00;
    endcase
  end
  assign stat_rd = bus.rd && (bus.addr == REG_FAULT_STATUS);

  // ==========================================================
  // next state
  always_comb begin
    n = s;
    n.spd_s1 = speed_pin;
    n.spd_s2 = s.spd_s1;
    n.dir_s1 = direction_input;
    n.dir_s2 = s.dir_s1;
    // pwm duty measured as high samples in a window
    n.win = (s.win == 9'h000) ? PWM_WIN : 9'(s.win - 9'h001);
    n.high = 9'(s.high + {8'h00, s.spd_s2});
    if (s.win == 9'h000) begin
      n.pwm_cmd = s.high;
      n.high = {8'h00, s.spd_s2};
    end
    // command source select and cap
    case (s.cfg[CFG_MODE][SRC_MSB:SRC_LSB])
      SRC_PWM:    cmd = s.pwm_cmd;
      SRC_ANALOG: cmd = speed_adc;
      SRC_I2C:    cmd = s.speed_i2c;
      default:    cmd = 9'h000;
    endcase
    cap = {s.cfg[CFG_DUTY_CAP], 1'b1};
    target = (cmd > cap) ? cap : cmd;
    // duty ramps toward target unless a limiter holds it
    n.ramp = 8'(s.ramp + 8'h01);
    if (s.ramp == RAMP_TOP) begin
      if (s.duty < target && !duty_hold) begin
        n.duty = 9'(s.duty + 9'h001);
      end else if (s.duty > target && !avs_hold) begin
        n.duty = 9'(s.duty - 9'h001);
      end
    end
    // thermal trip with hysteresis
    if (temp_code > THERMAL_TRIP) begin
      n.hot = 1'b1;
    end else if (temp_code < 8'(THERMAL_TRIP - THERMAL_HYS)) begin
      n.hot = 1'b0;
    end
    // overcurrent level and sticky flag, set beats read clear
    n.oc = phase_current > s.cfg[CFG_OC_THR];
    n.oc_flag = n.oc | (s.oc_flag & ~stat_rd);
    // lock stop, release wait and retry
    if (s.lock_wait) begin
      if (s.lock_timer == 30'h0) n.lock_wait = 1'b0;
      else n.lock_timer = 30'(s.lock_timer - 30'h1);
    end else if (lock_detect && !s.ld_busy) begin
      n.lock_wait = 1'b1;
      n.lock_timer = 30'(LOCK_CYCLES - 1);
      n.cause = lock_cause;
    end
    drive_en = !n.hot && !n.oc && !n.lock_wait && !s.ld_busy;
    // commutation rate follows duty
    {n.step, n.acc} = 17'({1'b0, s.acc} + 17'(s.duty));
    n.step = n.step && drive_en;
    if (turn) n.tach = !s.tach;
    // measurements
    n.cur = phase_current;
    n.sup_cnt = 11'(s.sup_cnt - 11'h001);
    if (s.sup_cnt == 11'h000) begin
      n.sup = supply_adc;
      n.sup_cnt = 11'(SUPPLY_CYCLES - 1);
    end
    // eeprom copy, one word a cycle
    if (s.ld_pend) n.cfg[s.ld_slot] = ee_data;
    n.ld_pend = s.ld_busy;
    n.ld_slot = s.ee_addr;
    if (s.ld_busy) begin
      if (s.ee_addr == CFG_LAST) n.ld_busy = 1'b0;
      else n.ee_addr = 4'(s.ee_addr + 4'h1);
    end
    if (sleep_exit) begin
      n.ld_busy = 1'b1;
      n.ee_addr = 4'h0;
    end
    // host writes override loaded values
    if (bus.wr && !s.ld_busy && !s.ld_pend) begin
      if (bus.addr == REG_SPEED_LO) n.speed_i2c[7:0] = bus.wdata;
      if (bus.addr == REG_SPEED_HI) n.speed_i2c[8] = bus.wdata[0];
      if (cfg_idx < 8'(CFG_WORDS)) n.cfg[cfg_idx[3:0]] = bus.wdata;
    end
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.ld_busy <= 1'b1;
      s.win <= PWM_WIN;
    end else begin
      s <= n;
    end
  end

  assign sda_out         = 1'b0;
  assign ee_addr         = s.ee_addr;
  assign tach_output     = s.tach;
  assign vreg_target_3v3 = s.cfg[CFG_MODE][BIT_VREG_SEL];

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_vreg_write: assert property (
    bus.wr && bus.addr == REG_CFG_BASE && !s.ld_busy && !s.ld_pend
    |=> vreg_target_3v3 == $past(bus.wdata[0]))
    else $error("regulator select not taken from write");
  chk_hot_trip: assert property (
    temp_code > THERMAL_TRIP |=> status[BIT_OVER_TEMP] &&
    phase_drive.en == 3'h0)
    else $error("thermal trip not reported or drive kept");
  chk_hot_hold: assert property (
    s.hot && temp_code >= 8'(THERMAL_TRIP - THERMAL_HYS) |=> s.hot)
    else $error("thermal shutdown released too early");
  chk_oc_hiz: assert property (
    phase_current > s.cfg[CFG_OC_THR] |=> phase_drive.en == 3'h0)
    else $error("drivers not high impedance on overcurrent");
  chk_oc_flag: assert property (
    phase_current > s.cfg[CFG_OC_THR] |=> status[BIT_OVER_CURR])
    else $error("overcurrent flag not set");
  chk_lock_stop: assert property (
    $rose(s.lock_wait) |-> phase_drive.en == 3'h0 &&
    s.cause == $past(lock_cause))
    else $error("lock did not stop drive or record cause");
  chk_lock_retry: assert property (
    $fell(s.lock_wait) |-> $past(s.lock_timer) == 30'h0)
    else $error("lock released before delay");
  chk_lock_flag: assert property (
    s.lock_wait |-> status[BIT_LOCK] && phase_drive.en == 3'h0)
    else $error("lock flag or stop missing");
  chk_ground_phase: assert property (
    phase_drive.en == 3'h7 |-> phase_drive.pwm != 3'h7)
    else $error("no phase held at ground");
  chk_tach_toggle: assert property (
    turn |=> tach_output != $past(tach_output))
    else $error("tach did not toggle");
  chk_duty_ramp: assert property (
    s.ramp == RAMP_TOP && s.duty < target && !duty_hold
    |=> s.duty == 9'($past(s.duty) + 9'h001))
    else $error("duty did not ramp up");

  cov_lock_retry: cover property ($fell(s.lock_wait));
  cov_host_write: cover property (bus.wr && !s.ld_busy);
  cov_thermal: cover property ($fell(s.hot));

endmodule
`default_nettype wire

// ### rtl/bsd_pkg.sv
// constants and carrier types shared by the sine drive core
// assumes one 200 MHz clock and a byte-wide register space on i2c
package bsd_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_SPEED_LO     = 8'h00;
  localparam logic [7:0] REG_SPEED_HI     = 8'h01;
  localparam logic [7:0] REG_FAULT_STATUS = 8'h10;
  localparam logic [7:0] REG_FAULT_CAUSE  = 8'h11;
  localparam logic [7:0] REG_CURRENT      = 8'h12;
  localparam logic [7:0] REG_SUPPLY       = 8'h13;
  localparam logic [7:0] REG_DUTY         = 8'h14;
  localparam logic [7:0] REG_CFG_BASE     = 8'h20;
  localparam int         CFG_WORDS        = 12;
  localparam logic [3:0] CFG_LAST         = 4'hb;

  // ==========================================================
  // field positions
  localparam int BIT_OVER_TEMP = 7;
  localparam int BIT_OVER_CURR = 5;
  localparam int BIT_LOCK      = 4;
  localparam int CFG_MODE      = 0;  // mode word index
  localparam int CFG_OC_THR    = 1;  // overcurrent threshold
  localparam int CFG_DUTY_CAP  = 2;  // peak duty cap, upper 8 bits
  localparam int BIT_VREG_SEL  = 0;  // output_voltage_select
  localparam int SRC_LSB       = 1;  // speed source, two bits
  localparam int SRC_MSB       = 2;

  // speed command sources
  localparam logic [1:0] SRC_PWM    = 2'h0;
  localparam logic [1:0] SRC_ANALOG = 2'h1;
  localparam logic [1:0] SRC_I2C    = 2'h2;

  // ==========================================================
  // thresholds and timing
  localparam logic [7:0] THERMAL_TRIP = 8'h96;  // 150 degC code
  localparam logic [7:0] THERMAL_HYS  = 8'h0a;  // 10 degC code
  localparam int CLK_KHZ          = 200000;
  localparam int LOCK_OFF_MS      = 5000;
  localparam int LOCK_OFF_CYCLES  = LOCK_OFF_MS * CLK_KHZ;
  localparam int SUPPLY_SAMPLE_US = 10;
  localparam int SUPPLY_CYCLES    = SUPPLY_SAMPLE_US * CLK_KHZ / 1000;
  localparam logic [8:0] PWM_WIN  = 9'h1fe;  // 511 samples a window
  localparam logic [7:0] RAMP_TOP = 8'hff;   // duty ramp divider
  localparam logic [6:0] I2C_ADDR = 7'h52;   // arbitrary value

  // ==========================================================
  // sine table placement
  localparam logic [8:0] SINE_MID = 9'h094;
  localparam logic [5:0] PH_B_OFS = 6'h15;
  localparam logic [5:0] PH_C_OFS = 6'h2b;

  // per-phase drive: pwm high side, enable low means high impedance
  typedef struct packed {
    logic [2:0] pwm;
    logic [2:0] en;
  } bsd_phase_t;

  // register access from the i2c target
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } bsd_bus_t;

endpackage

// ### rtl/bsd_sine_mod.sv
// sine with third harmonic, one phase clamped low, eight-bit carrier
// assumes step pulses come from the core's commutation divider
`timescale 1ns/1ps
`default_nettype none
module bsd_sine_mod import bsd_pkg::*; (
  input  wire logic       clock,    // 200 MHz
  input  wire logic       reset,    // async, high
  input  wire logic       step,     // advance electrical angle
  input  wire logic       reverse,  // run angle backwards
  input  wire logic [8:0] peak,     // output_duty_peak
  input  wire logic       enable,   // drivers allowed
  output var  bsd_phase_t drive,    // phase pwm and enables
  output logic            turn      // half-turn pulse
);

  typedef struct packed {
    logic [5:0] phase;
    logic [7:0] cnt;
    bsd_phase_t drive;
    logic       turn;
  } bsd_sine_t;

  bsd_sine_t s, n;

  // quarter-wave table, amplitude 147 around SINE_MID
  function automatic logic [8:0] sin_u(input logic [5:0] p);
    logic [4:0] q;
    logic [7:0] m;
    q = p[4] ? 5'(5'h10 - {1'b0, p[3:0]}) : {1'b0, p[3:0]};
    case (q)
      5'h00: m = 8'h00;  5'h01: m = 8'h0e;  5'h02: m = 8'h1d;
      5'h03: m = 8'h2b;  5'h04: m = 8'h38;  5'h05: m = 8'h45;
      5'h06: m = 8'h52;  5'h07: m = 8'h5d;  5'h08: m = 8'h68;
      5'h09: m = 8'h72;  5'h0a: m = 8'h7a;  5'h0b: m = 8'h82;
      5'h0c: m = 8'h88;  5'h0d: m = 8'h8d;  5'h0e: m = 8'h90;
      5'h0f: m = 8'h92;  5'h10: m = 8'h93;
      default: m = 8'h00;
    endcase
    sin_u = p[5] ? 9'(SINE_MID - {1'b0, m}) : 9'(SINE_MID + {1'b0, m});
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    logic [2:0][8:0] sv;
    logic [8:0]      lo;
    logic [16:0]     prod;
    n = s;
    sv = '0;
    lo = '0;
    prod = '0;
    n.cnt = 8'(s.cnt + 8'h01);
    n.turn = 1'b0;
    // direction sets angle sense
    if (step) begin
      n.phase = reverse ? 6'(s.phase - 6'h01) : 6'(s.phase + 6'h01);
      n.turn = (n.phase[4:0] == 5'h00);
    end
    sv[0] = sin_u(s.phase);
    sv[1] = sin_u(6'(s.phase + PH_B_OFS));
    sv[2] = sin_u(6'(s.phase + PH_C_OFS));
    lo = (sv[0] < sv[1]) ? sv[0] : sv[1];
    lo = (sv[2] < lo) ? sv[2] : lo;
    // lowest phase sits at zero, others scaled by the peak
    for (int i = 0; i < 3; i++) begin
      prod = 17'(sv[i] - lo) * 17'(peak);
      n.drive.pwm[i] = enable && (s.cnt < prod[16:9]);
    end
    n.drive.en = {3{enable}};
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign drive = s.drive;
  assign turn  = s.turn;

endmodule
`default_nettype wire

// ### rtl/bsd_i2c_tgt.sv
// i2c target: pointer byte then data bytes, auto-increment both ways
// assumes scl and sda come straight from pins, sda open drain
`timescale 1ns/1ps
`default_nettype none
module bsd_i2c_tgt import bsd_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = I2C_ADDR  // target address
) (
  input  wire logic       clock,    // 200 MHz
  input  wire logic       reset,    // async, high
  input  wire logic       scl_pin,  // serial clock pin
  input  wire logic       sda_pin,  // serial data pin level
  input  wire logic [7:0] rdata,    // value at bus.addr
  output logic            sda_oe,   // pull sda low
  output var  bsd_bus_t   bus       // register access
);

  typedef enum logic [5:0] {
    I_IDLE = 6'h01, I_ADDR = 6'h02, I_WR = 6'h04,
    I_ACK  = 6'h08, I_RD   = 6'h10, I_RACK = 6'h20
  } bsd_i2c_st_t;

  typedef struct packed {
    logic        scl1, scl2, scl3, sda1, sda2, sda3;
    bsd_i2c_st_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh, ptr;
    logic        first, rw, oe;
    bsd_bus_t    bus;
  } bsd_i2c_t;

  bsd_i2c_t s, n;
  logic rise, fall;

  // ==========================================================
  // next state
  always_comb begin
    n = s;
    n.scl1 = scl_pin;
    n.scl2 = s.scl1;
    n.scl3 = s.scl2;
    n.sda1 = sda_pin;
    n.sda2 = s.sda1;
    n.sda3 = s.sda2;
    n.bus.wr = 1'b0;
    n.bus.rd = 1'b0;
    rise = s.scl2 & ~s.scl3;
    fall = ~s.scl2 & s.scl3;
    if (s.bus.wr || s.bus.rd) begin
      n.ptr = 8'(s.ptr + 8'h01);
    end
    if (s.scl2 && s.scl3 && s.sda3 && !s.sda2) begin
      n.st = I_ADDR;
      n.cnt = 4'h0;
      n.first = 1'b1;
      n.oe = 1'b0;
    end else if (s.scl2 && s.scl3 && !s.sda3 && s.sda2) begin
      n.st = I_IDLE;
      n.oe = 1'b0;
    end else if (rise) begin
      case (s.st)
        I_ADDR, I_WR: begin
          n.sh = {s.sh[6:0], s.sda2};
          n.cnt = 4'(s.cnt + 4'h1);
        end
        I_RACK: if (s.sda2) n.st = I_IDLE;
        default: ;
      endcase
    end else if (fall) begin
      case (s.st)
        I_ADDR: if (s.cnt == 4'h8) begin
          n.st = (s.sh[7:1] == DEV_ADDR) ? I_ACK : I_IDLE;
          n.oe = (s.sh[7:1] == DEV_ADDR);
          n.rw = s.sh[0];
        end
        I_WR: if (s.cnt == 4'h8) begin
          n.st = I_ACK;
          n.oe = 1'b1;
          n.first = 1'b0;
          if (s.first) n.ptr = s.sh;
          n.bus.wr = !s.first;
          n.bus.wdata = s.sh;
        end
        I_ACK, I_RACK: begin
          n.cnt = 4'h1;
          n.st = s.rw ? I_RD : I_WR;
          n.oe = s.rw && !rdata[7];
          n.sh = rdata;
          n.bus.rd = s.rw;
          if (!s.rw) n.cnt = 4'h0;
        end
        I_RD: if (s.cnt == 4'h8) begin
          n.st = I_RACK;
          n.oe = 1'b0;
        end else begin
          n.sh = {s.sh[6:0], 1'b0};
          n.oe = !s.sh[6];
          n.cnt = 4'(s.cnt + 4'h1);
        end
        default: ;
      endcase
    end
    n.bus.addr = n.ptr;
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
      s.st <= I_IDLE;
      s.scl1 <= 1'b1;
      s.scl2 <= 1'b1;
      s.scl3 <= 1'b1;
      s.sda1 <= 1'b1;
      s.sda2 <= 1'b1;
      s.sda3 <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign sda_oe = s.oe;
  assign bus    = s.bus;

endmodule
`default_nettype wire

// ### verification/bsd_host.sv
// i2c host model that sits on the far side of the register pins
// assumes a pull-up on sda and open-drain pulls from both parties
`timescale 1ns/1ps
`default_nettype none
module bsd_host import bsd_pkg::*; #(
  parameter logic [6:0] ADDR = I2C_ADDR  // target address
) (
  input  wire logic clock,    // bench clock
  input  wire logic sda,      // resolved data line
  output logic      scl,      // serial clock
  output logic      sda_low,  // host pulls data low
  output logic      nak       // a target ack went missing
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    nak = 1'b0;
  end
  // ==========================================================
  // bit level: scl halves of ten clocks each
  task automatic tick();
    repeat (10) @(posedge clock);
  endtask
  task automatic put(input logic b, output logic r);
    sda_low <= ~b;
    tick();
    scl <= 1'b1;
    tick();
    r = sda;
    scl <= 1'b0;
  endtask
  task automatic start();
    sda_low <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b0;
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_low <= 1'b0;
    tick();
  endtask
  // one byte msb first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put(d[i], r);
      q[i] = r;
    end
    put(a, r);
    if (a && r)
      nak = 1'b1;
  endtask
  // ==========================================================
  // register transactions
  task automatic wr(input logic [7:0] ra, input logic [7:0] v);
    logic [7:0] q;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q);
    xfer(ra, 1'b1, q);
    xfer(v, 1'b1, q);
    stop();
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] v);
    logic [7:0] q;
    logic       k;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q);
    xfer(ra, 1'b1, q);
    start();
    xfer({ADDR, 1'b1}, 1'b1, q);
    k = nak;
    xfer(8'hff, 1'b1, v);  // host nack ends the read, no target ack
    nak = k;
    stop();
  endtask
endmodule
`default_nettype wire

// ### verification/bldc_sine_drive_core_bench.sv
// self-checking bench for the sine drive core
// assumes the host model above and an eeprom table kept here
`timescale 1ns/1ps
`default_nettype none
module bldc_sine_drive_core_bench import bsd_pkg::*; ;
  logic clock, reset, speed_pin, direction_input, lock_detect;
  logic sleep_exit, sda_out, sda_oe, scl, sda_low, tach_output;
  logic vreg, nak, duty_hold, avs_hold;
  logic [8:0] speed_adc;
  logic [7:0] temp_code, phase_current, supply_adc, ee_data, q, cur;
  logic [2:0] lock_cause;
  logic [3:0] ee_addr;
  logic [31:0] seed = 32'h49784f81;
  logic [7:0] ee_mem [12];
  bsd_phase_t phase_drive;
  int n_mismatch, tests_run;
  logic [7:0] cfg [12];
  wire logic sda = ~(sda_low | sda_oe);

  bsd_core #(.LOCK_CYCLES(3000)) u_bsd_core (.clock(clock),
    .reset(reset), .scl_pin(scl), .sda_pin(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .speed_pin(speed_pin), .speed_adc(speed_adc),
    .direction_input(direction_input), .temp_code(temp_code),
    .phase_current(phase_current), .supply_adc(supply_adc),
    .lock_detect(lock_detect), .lock_cause(lock_cause),
    .duty_hold(duty_hold), .avs_hold(avs_hold), .sleep_exit(sleep_exit),
    .ee_data(ee_data), .ee_addr(ee_addr), .phase_drive(phase_drive),
    .tach_output(tach_output), .vreg_target_3v3(vreg));
  bsd_host u_bsd_host (.clock(clock), .sda(sda), .scl(scl),
    .sda_low(sda_low), .nak(nak));

  // ==========================================================
  // clock, eeprom word one cycle after its index, random pins
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  always @(posedge clock) begin
    ee_data <= ee_mem[ee_addr];
    seed <= xs(seed);
    speed_pin <= seed[0];
    speed_adc <= seed[9:1];
    direction_input <= seed[10];
  end
  // ==========================================================
  // compare and verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    results();
  end
  // ==========================================================
  // main sequence
  initial begin
    foreach (ee_mem[i]) ee_mem[i] = 8'h00;
    ee_mem[1] = 8'h80;
    ee_mem[2] = 8'hff;
    foreach (cfg[i]) cfg[i] = ee_mem[i];
    {reset, lock_detect, sleep_exit, lock_cause} = 6'h20;
    {duty_hold, avs_hold} = 2'h0;
    temp_code = 8'h19;
    supply_adc = 8'h00;
    phase_current = 8'h00;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    cur = 8'(xs(seed ^ 32'h5a)) & 8'h7f;
    phase_current <= cur;
    supply_adc <= cur ^ 8'hc3;
    repeat (30) @(posedge clock);
    chk({7'h0, vreg}, cfg[0][0]);
    cfg[0] = 8'h05;
    u_bsd_host.wr(8'h20, 8'h05);
    repeat (8) @(posedge clock);
    chk({7'h0, vreg}, cfg[0][0]);
    u_bsd_host.rd(8'h20, q);
    chk(q, cfg[0]);
    u_bsd_host.wr(8'h00, 8'h10);
    u_bsd_host.wr(8'h01, 8'h00);
    repeat (4800) @(posedge clock);
    u_bsd_host.rd(8'h14, q);
    chk(q, 8'h08);
    // limiters freeze the duty against a new command
    duty_hold <= 1'b1;
    u_bsd_host.wr(8'h00, 8'h40);
    u_bsd_host.rd(8'h14, q);
    chk(q, 8'h08);
    avs_hold <= 1'b1;
    u_bsd_host.wr(8'h00, 8'h00);
    u_bsd_host.rd(8'h14, q);
    chk(q, 8'h08);
    {duty_hold, avs_hold} <= 2'h0;
    u_bsd_host.rd(8'h12, q);
    chk(q, cur);
    u_bsd_host.rd(8'h13, q);
    chk(q, cur ^ 8'hc3);
    phase_current <= 8'h81;
    repeat (2) @(posedge clock);
    chk({5'h0, phase_drive.en}, 8'h00);
    phase_current <= cur;
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h20);
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h00);
    temp_code <= 8'h97;
    repeat (3) @(posedge clock);
    chk({5'h0, phase_drive.en}, 8'h00);
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h80);
    temp_code <= 8'h8c;
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h80);
    temp_code <= 8'h8b;
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h00);
    chk({5'h0, phase_drive.en}, 8'h07);
    lock_cause <= 3'h5;
    lock_detect <= 1'b1;
    repeat (2) @(posedge clock);
    chk({5'h0, phase_drive.en}, 8'h00);
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h10);
    u_bsd_host.rd(8'h11, q);
    chk(q, 8'h05);
    // lock still present past the release time: a new stop cycle
    repeat (2600) @(posedge clock);
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h10);
    lock_detect <= 1'b0;
    repeat (3200) @(posedge clock);
    u_bsd_host.rd(8'h10, q);
    chk(q, 8'h00);
    chk({5'h0, phase_drive.en}, 8'h07);
    sleep_exit <= 1'b1;
    @(posedge clock);
    sleep_exit <= 1'b0;
    repeat (30) @(posedge clock);
    chk({7'h0, vreg}, ee_mem[0][0]);
    chk({7'h0, nak}, 8'h00);
    results();
  end
endmodule
`default_nettype wire
